// file: src/arb_builder.v
// APB-reached engine that assembles the attestation record from staged identity fields.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "arb_regs.vh"
module arb_builder #(
  // Arbitrary value standing in for the device root secret.
  parameter [127:0] ROOT_SECRET = 128'h5a5a_1234_0f0f_abcd_9876_c3c3_0101_7e7e
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  output wire        record_ready,
  output wire        busy
);
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_KEY   = 4'b0010;
  localparam [3:0] ST_BUILD = 4'b0100;
  localparam [3:0] ST_FIN   = 4'b1000;

  reg  [31:0]  stage_mem [0:107];
  reg  [31:0]  desc_mem  [0:31];
  reg  [31:0]  rec_mem   [0:107];

  reg  [3:0]   state;
  reg  [6:0]   idx;
  reg  [127:0] rkey;
  reg          feat;
  reg          done;
  reg          align_err;
  reg  [31:0]  desc_addr;
  reg  [31:0]  rec_addr;
  reg  [31:0]  next_rdata;
  reg          next_err;
  reg  [31:0]  tag_word;

  wire         setup;
  wire         access;
  wire [2:0]   region;
  wire [6:0]   widx;
  wire         in_ctrl;
  wire         in_stage;
  wire         in_desc;
  wire         in_rec;
  wire         mapped;
  wire         wr_ok;
  wire         wr_go;
  wire         start;
  wire         addr_bad;
  wire [31:0]  stage_rd;
  wire [31:0]  desc_rd;
  wire [31:0]  rec_word;
  wire         mac_init;
  wire         mac_valid;
  wire [127:0] tag;
  wire         rec_we;
  wire [6:0]   rec_waddr;
  wire [31:0]  rec_wdata;

  // Byte-lane merge for APB4 write strobes.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Record word at word index w, taking staged data s wherever a field lives there.
  function [31:0] build_word;
    input [6:0]  w;
    input [31:0] s;
    input        f;
    begin
      build_word = 32'h00000000;
      if (w < `ARB_W_MISC) begin
        build_word = s;
      end else if (w == `ARB_W_MISC) begin
        build_word = s;
      end else if (w == `ARB_W_FLOW) begin
        build_word = {24'h000000, f ? s[7:0] : 8'h00};
      end else if (w >= `ARB_W_EXT && w < `ARB_W_ATTR) begin
        build_word = s;
      end else if (w >= `ARB_W_ATTR && w < `ARB_W_MEAS) begin
        build_word = s;
      end else if (w >= `ARB_W_MEAS && w < `ARB_W_RSV96) begin
        build_word = s;
      end else if (w >= `ARB_W_SIGN && w < `ARB_W_RSV160) begin
        build_word = s;
      end else if (w >= `ARB_W_CFG && w < `ARB_W_PROD) begin
        build_word = s;
      end else if (w == `ARB_W_PROD) begin
        build_word = s;
      end else if (w == `ARB_W_CSVN) begin
        build_word = {16'h0000, s[15:0]};
      end else if (w >= `ARB_W_FAM && w < `ARB_W_USER) begin
        build_word = s;
      end else if (w >= `ARB_W_USER && w < `ARB_W_NONCE) begin
        build_word = s;
      end else if (w >= `ARB_W_NONCE && w < `ARB_W_MAC) begin
        build_word = s;
      end
    end
  endfunction

  // Bits of descriptor word w that carry target identity; reserved bytes never reach the key.
  function [31:0] desc_mask;
    input [4:0] w;
    input       f;
    begin
      desc_mask = 32'h00000000;
      if (w < `ARB_T_ATTR) begin
        desc_mask = 32'hffffffff;
      end else if (w < `ARB_T_FLOW) begin
        desc_mask = 32'hffffffff;
      end else if (w == `ARB_T_FLOW) begin
        desc_mask = {16'hffff, 8'h00, f ? 8'hff : 8'h00};
      end else if (w == `ARB_T_MISC) begin
        desc_mask = 32'hffffffff;
      end else if (w >= `ARB_T_CFG) begin
        desc_mask = 32'hffffffff;
      end
    end
  endfunction

  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign region   = paddr[11:9];
  assign widx     = paddr[8:2];
  assign in_ctrl  = (region == `ARB_RGN_CTRL) && (paddr[8:4] == 5'h00);
  assign in_stage = (region == `ARB_RGN_STAGE) && (widx < `ARB_REC_WORDS);
  assign in_desc  = (region == `ARB_RGN_DESC) && (widx < `ARB_DESC_WORDS);
  assign in_rec   = (region == `ARB_RGN_REC) && (widx < `ARB_REC_WORDS);
  assign mapped   = in_ctrl | in_stage | in_desc | in_rec;
  assign busy     = ~state[0];
  assign pready   = 1'b1;
  assign record_ready = done;

  // Staged inputs and setup are frozen during a build so the record stays self-consistent.
  assign wr_ok = mapped & ~in_rec & (~busy | (in_ctrl & (paddr == `ARB_STAT_OFF)));

  // The error was decided at setup; a write refused there must not land if busy drops meanwhile.
  assign wr_go = access & pwrite & wr_ok & ~pslverr;

  assign start = access & pwrite & ~busy & (paddr == `ARB_CTRL_OFF) & in_ctrl &
                 pstrb[0] & pwdata[`ARB_CTRL_START];

  // The descriptor location and the destination must both sit on 512-byte boundaries.
  assign addr_bad = (desc_addr[`ARB_ALIGN_BITS-1:0] != 9'h000) |
                    (rec_addr[`ARB_ALIGN_BITS-1:0] != 9'h000);

  always @* begin
    next_rdata = 32'h00000000;
    next_err   = ~mapped | (pwrite & ~wr_ok);
    if (!pwrite) begin
      if (in_ctrl) begin
        case (paddr)
          `ARB_CTRL_OFF: begin
            next_rdata = {30'h0, feat, 1'b0};
          end
          `ARB_STAT_OFF: begin
            next_rdata = {29'h0, align_err, done, busy};
          end
          `ARB_DESC_ADDR_OFF: begin
            next_rdata = desc_addr;
          end
          `ARB_REC_ADDR_OFF: begin
            next_rdata = rec_addr;
          end
          default: begin
            next_rdata = 32'h00000000;
          end
        endcase
      end else if (in_stage) begin
        next_rdata = stage_mem[widx];
      end else if (in_desc) begin
        next_rdata = desc_mem[widx[4:0]];
      end else if (in_rec) begin
        next_rdata = rec_mem[widx];
      end
    end
  end

  // Answer data is captured in the setup phase so it stands from flops through the access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= next_rdata;
      pslverr <= next_err;
    end
  end

  always @(posedge pclk) begin
    if (wr_go & in_stage) begin
      stage_mem[widx] <= merge(stage_mem[widx], pwdata, pstrb);
    end
    if (wr_go & in_desc) begin
      desc_mem[widx[4:0]] <= merge(desc_mem[widx[4:0]], pwdata, pstrb);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat      <= 1'b0;
      desc_addr <= `ARB_ADDR_RST;
      rec_addr  <= `ARB_ADDR_RST;
    end else if (wr_go & in_ctrl) begin
      case (paddr)
        `ARB_CTRL_OFF: begin
          if (pstrb[0]) begin
            feat <= pwdata[`ARB_CTRL_FEAT];
          end
        end
        `ARB_DESC_ADDR_OFF: begin
          desc_addr <= merge(desc_addr, pwdata, pstrb);
        end
        `ARB_REC_ADDR_OFF: begin
          rec_addr <= merge(rec_addr, pwdata, pstrb);
        end
        default: begin
          feat <= feat;
        end
      endcase
    end
  end

  assign stage_rd = stage_mem[idx];
  assign desc_rd  = desc_mem[idx[4:0]];
  assign rec_word = build_word(idx, stage_rd, feat);

  always @* begin
    case (idx[1:0])
      2'd0: tag_word = tag[31:0];
      2'd1: tag_word = tag[63:32];
      2'd2: tag_word = tag[95:64];
      default: tag_word = tag[127:96];
    endcase
  end

  assign mac_init  = state[2] & (idx == 7'd0);
  assign mac_valid = state[2];
  assign rec_we    = state[2] | state[3];
  assign rec_waddr = state[3] ? (`ARB_W_MAC + idx) : idx;
  assign rec_wdata = state[3] ? tag_word : rec_word;

  always @(posedge pclk) begin
    if (rec_we) begin
      rec_mem[rec_waddr] <= rec_wdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      idx       <= 7'd0;
      rkey      <= 128'h0;
      done      <= 1'b0;
      align_err <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            done      <= 1'b0;
            idx       <= 7'd0;
            align_err <= addr_bad;
            if (!addr_bad) begin
              rkey  <= ROOT_SECRET;
              state <= ST_KEY;
            end
          end
        end
        ST_KEY: begin
          // Only the chosen target can rebuild this key from its own identity.
          rkey <= {rkey[94:0], rkey[127:95]} ^
                  {4{desc_rd & desc_mask(idx[4:0], feat)}};
          if (idx[4:0] == `ARB_DESC_LAST) begin
            idx   <= 7'd0;
            state <= ST_BUILD;
          end else begin
            idx <= idx + 7'd1;
          end
        end
        ST_BUILD: begin
          if (idx == `ARB_MAC_LAST) begin
            idx   <= 7'd0;
            state <= ST_FIN;
          end else begin
            idx <= idx + 7'd1;
          end
        end
        ST_FIN: begin
          if (idx == `ARB_TAG_LAST) begin
            idx   <= 7'd0;
            done  <= 1'b1;
            state <= ST_IDLE;
          end else begin
            idx <= idx + 7'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
          idx   <= 7'd0;
        end
      endcase
    end
  end

  arb_mac u_mac (
    .pclk       (pclk),
    .presetn    (presetn),
    .init       (mac_init),
    .key        (rkey),
    .word_valid (mac_valid),
    .word       (rec_word),
    .tag        (tag)
  );
endmodule

// file: src/arb_regs.vh
// Register map, record layout and field positions of the attestation record builder.
`ifndef ARB_REGS_VH
`define ARB_REGS_VH

`define ARB_CTRL_OFF      12'h000
`define ARB_STAT_OFF      12'h004
`define ARB_DESC_ADDR_OFF 12'h008
`define ARB_REC_ADDR_OFF  12'h00c
`define ARB_RGN_CTRL      3'h0
`define ARB_RGN_STAGE     3'h1
`define ARB_RGN_DESC      3'h2
`define ARB_RGN_REC       3'h3

`define ARB_CTRL_START    0
`define ARB_CTRL_FEAT     1
`define ARB_STAT_BUSY     0
`define ARB_STAT_DONE     1
`define ARB_STAT_ALIGN    2
`define ARB_CTRL_RST      32'h00000000
`define ARB_ADDR_RST      32'h00000000
`define ARB_ALIGN_BITS    9

`define ARB_W_PSV         7'd0
`define ARB_W_MISC        7'd4
`define ARB_W_FLOW        7'd5
`define ARB_W_EXT         7'd8
`define ARB_W_ATTR        7'd12
`define ARB_W_MEAS        7'd16
`define ARB_W_RSV96       7'd24
`define ARB_W_SIGN        7'd32
`define ARB_W_RSV160      7'd40
`define ARB_W_CFG         7'd48
`define ARB_W_PROD        7'd64
`define ARB_W_CSVN        7'd65
`define ARB_W_FAM         7'd76
`define ARB_W_USER        7'd80
`define ARB_W_NONCE       7'd96
`define ARB_W_MAC         7'd104
`define ARB_REC_WORDS     7'd108

`define ARB_T_MEAS        5'd0
`define ARB_T_ATTR        5'd8
`define ARB_T_FLOW        5'd12
`define ARB_T_MISC        5'd13
`define ARB_T_CFG         5'd16
`define ARB_DESC_WORDS    7'd32
`define ARB_DESC_LAST     5'd31
`define ARB_MAC_LAST      7'd103
`define ARB_TAG_LAST      7'd3

`endif

// file: src/arb_mac.v
// Keyed tag accumulator that folds record words into a 128-bit authentication code.
`timescale 1ns/10ps
module arb_mac (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         init,
  input  wire [127:0] key,
  input  wire         word_valid,
  input  wire [31:0]  word,
  output wire [127:0] tag
);
  reg  [127:0] acc;
  wire [127:0] base;
  wire [127:0] mix;
  wire [127:0] rot;

  // Loading the key and the first word in one cycle avoids a dead cycle per record.
  assign base = init ? key : acc;
  assign mix  = base ^ {word, word ^ key[95:64], ~word, word ^ key[31:0]};
  assign rot  = {mix[98:0], mix[127:99]};
  assign tag  = acc;

  // The mixing is a structural stand-in; a real cipher drops in behind the same ports.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 128'h0;
    end else if (word_valid) begin
      acc <= rot + {key[63:0], key[127:64]};
    end
  end
endmodule

// file: tb/arb_builder_properties.sv
// Concurrent checks on the record builder's bus and build-status ports.
`timescale 1ns/10ps
module arb_builder_properties (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        record_ready,
  input logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic go;
  logic d_ok;
  logic r_ok;
  assign acc = psel && penable;
  assign go  = acc && pwrite && paddr[11:2] == 10'h0 && pstrb[0] && pwdata[0] && !busy;
  // Alignment is tracked from any write made while not busy, ignoring strobes, since the bench issues only full-word writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_ok <= 1'h1;
      r_ok <= 1'h1;
    end else if (acc && pwrite && !busy) begin
      if (paddr == 12'h008) d_ok <= pwdata[8:0] == 9'h0;
      if (paddr == 12'h00c) r_ok <= pwdata[8:0] == 9'h0;
    end
  end
  a_start_clears: assert property (go |=> !record_ready)
    else $error("done not cleared by start");
  a_align_gate: assert property (go |=> busy == (d_ok && r_ok))
    else $error("build start ignores alignment");
  a_build_len: assert property ($rose(busy) |-> ##139 busy ##1 (!busy && record_ready))
    else $error("build length wrong");
  a_busy_no_done: assert property (busy |-> !record_ready)
    else $error("done during build");
  a_record_ro: assert property (acc && pwrite && paddr >= 12'h600 && paddr < 12'h7b0 |-> pslverr)
    else $error("record write accepted");
  a_desc_lock: assert property (acc && pwrite && busy && paddr[11:7] == 5'h08 |-> pslverr)
    else $error("descriptor write accepted while busy");
  a_unmapped: assert property (acc && paddr >= 12'h010 && paddr < 12'h200
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_status_view: assert property (acc && !pwrite && paddr[11:2] == 10'h1
    |-> prdata[1:0] == {$past(record_ready), $past(busy)})
    else $error("status read disagrees with ports");
  a_done_hold: assert property (!busy && record_ready && !go |=> record_ready)
    else $error("done dropped without start");
  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase not completed at once");
  c_start: cover property (go);
  c_finish: cover property ($fell(busy));
  c_refused: cover property (acc && pslverr);
endmodule

// file: tb/arb_sw_model.sv
// Enclave software model: APB master that stages the descriptor and requests a build.
`timescale 1ns/10ps
module arb_sw_model (
  input  logic        pclk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Released address and data lines show the inverse so stale values are never mistaken for fresh ones.
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic put_desc(input int k, input logic [31:0] v);
    logic [31:0] r;
    logic        e;
    if (k == 14 || k == 15) v = 32'h0;
    if (k == 12) v[15:8] = 8'h0;
    xfer(1'h1, 12'h400 + 12'(4 * k), v, r, e);
  endtask
  task automatic request(input logic [31:0] da, input logic [31:0] ra, input logic feat);
    logic [31:0] r;
    logic        e;
    xfer(1'h1, 12'h008, da, r, e);
    xfer(1'h1, 12'h00c, ra, r, e);
    xfer(1'h1, 12'h000, {30'h0, feat, 1'h1}, r, e);
  endtask
endmodule

// file: tb/tb_attestation_report_builder.sv
// Self-checking bench for the attestation record builder.
`timescale 1ns/10ps
module tb_attestation_report_builder;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [3:0]   pstrb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         record_ready;
  logic         busy;
  logic [31:0]  stage [0:103];
  logic [31:0]  r;
  logic         e;
  logic [127:0] t0;
  logic [127:0] t1;
  int           mismatches = 0;
  int           n_tests = 0;
  int           cyc = 0;
  logic [31:0]  rs = 32'h5a00;

  arb_builder u_arb_builder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .record_ready(record_ready), .busy(busy));
  arb_sw_model u_arb_sw_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_err(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  function automatic logic [31:0] exp_word(input int w, input logic feat);
    if (w == 5) return feat ? {24'h0, stage[5][7:0]} : 32'h0;
    if (w == 65) return {16'h0, stage[65][15:0]};
    if (w < 5 || (w >= 8 && w < 24) || (w >= 32 && w < 40) || (w >= 48 && w < 65) || w >= 76)
      return stage[w];
    return 32'h0;
  endfunction
  task automatic build(input logic feat, output logic [127:0] tag);
    int n;
    u_arb_sw_model.request(32'h200, 32'h400, feat);
    u_arb_sw_model.xfer(1'h1, 12'h400, 32'h1, r, e);
    chk_err(e, 1'h1);
    u_arb_sw_model.xfer(1'h0, 12'h004, 32'h0, r, e);
    chk_word(r & 32'h3, 32'h1);
    n = 0;
    while (r[0] === 1'h1 && n < 200) begin
      u_arb_sw_model.xfer(1'h0, 12'h004, 32'h0, r, e);
      n++;
    end
    chk_word(r & 32'h7, 32'h2);
    for (int w = 0; w < 108; w++) begin
      u_arb_sw_model.xfer(1'h0, 12'h600 + 12'(4 * w), 32'h0, r, e);
      if (w < 104) chk_word(r, exp_word(w, feat));
      else tag[32 * (w - 104) +: 32] = r;
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    presetn = 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    u_arb_sw_model.xfer(1'h0, 12'h004, 32'h0, r, e);
    chk_word(r, 32'h0);
    chk_err(e, 1'h0);
    for (int w = 0; w < 104; w++) begin
      stage[w] = rnd();
      u_arb_sw_model.xfer(1'h1, 12'h200 + 12'(4 * w), stage[w], r, e);
    end
    for (int k = 0; k < 32; k++) u_arb_sw_model.put_desc(k, rnd());
    build(1'h0, t0);
    build(1'h1, t0);
    build(1'h1, t1);
    chk_word({31'h0, t0 === t1}, 32'h1);
    u_arb_sw_model.put_desc(0, rnd());
    build(1'h1, t0);
    chk_word({31'h0, t0 !== t1}, 32'h1);
    stage[80] = ~stage[80];
    u_arb_sw_model.xfer(1'h1, 12'h340, stage[80], r, e);
    build(1'h1, t1);
    chk_word({31'h0, t0 !== t1}, 32'h1);
    u_arb_sw_model.request(32'h210, 32'h400, 1'h1);
    u_arb_sw_model.xfer(1'h0, 12'h004, 32'h0, r, e);
    chk_word(r & 32'h7, 32'h4);
    u_arb_sw_model.request(32'h200, 32'h480, 1'h1);
    u_arb_sw_model.xfer(1'h0, 12'h004, 32'h0, r, e);
    chk_word(r & 32'h7, 32'h4);
    u_arb_sw_model.xfer(1'h0, 12'h100, 32'h0, r, e);
    chk_word(r, 32'h0);
    chk_err(e, 1'h1);
    u_arb_sw_model.xfer(1'h1, 12'h600, 32'h0, r, e);
    chk_err(e, 1'h1);
    tally_and_finish();
  end
endmodule

bind arb_builder arb_builder_properties u_arb_builder_properties (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .record_ready(record_ready), .busy(busy));
